// *** common/reset_seq_pkg.sv ***
package reset_seq_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_SYS_HZ      = 50_000_000;
    localparam int unsigned MODE_CYCLES     = 1025;
    localparam int unsigned PIN_LOW_CYCLES  = 3;
    localparam int unsigned PIN_HIGH_CYCLES = 4;
    localparam int unsigned DIP_CYCLES      = 4;
    localparam int unsigned SYNC_STAGES     = 2;

    localparam logic [10:0] MODE_LAST       = 11'(MODE_CYCLES - 1);
    localparam logic [2:0]  PIN_LOW_LAST    = 3'(PIN_LOW_CYCLES);
    localparam logic [2:0]  PIN_HIGH_LAST   = 3'(PIN_HIGH_CYCLES);
    localparam logic [2:0]  DIP_LAST        = 3'(DIP_CYCLES);

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [23:0] PC_RESET        = 24'h000000;
    localparam logic [1:0]  CLK_SRC_CRYSTAL = 2'h0;
    localparam int unsigned BROWNOUT_DISABLE_POS = 6;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_HOLD    = 4'b0001,
        ST_COUNT   = 4'b0010,
        ST_WAITPIN = 4'b0100,
        ST_RUN     = 4'b1000
    } seq_state_t;

    typedef struct packed {
        logic power_on;
        logic brownout_detect;
        logic watchdog_timeout;
        logic watchdog_reset_en;
        logic rtc_alarm;
        logic sleeping;
        logic debug_reset;
    } reset_req_t;

    typedef struct packed {
        logic        sys_reset;
        logic        cpu_run;
        logic        gpio_input_mode;
        logic [23:0] pc_value;
        logic [1:0]  clk_src;
    } reset_out_t;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync
    import reset_seq_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic [SYNC_STAGES-1:0] ff_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ff_q <= {SYNC_STAGES{1'b1}};
        end else begin
            ff_q <= {ff_q[SYNC_STAGES-2:0], d};
        end
    end

    assign q = ff_q[SYNC_STAGES-1];
endmodule

// *** logic/level_qual.sv ***
`timescale 1ns/1ns
module level_qual
    import reset_seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       level,
    input  wire logic [2:0] need,
    output logic            met
);
    logic [2:0] cnt_q;

    // Counts consecutive cycles of level high, saturating at need
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 3'h0;
        end else if (!level) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != need) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign met = (cnt_q == need);
endmodule

// *** logic/reset_sequencer.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] System reset restores defaults, makes GPIO inputs and clears the program counter.
// [RL2] Instruction execution is suspended while system reset is active.
// [RL3] Power-on, brownout, pin, watchdog, alarm and debug requests all reset alike.
// [RL4] Watchdog time-out resets only when watchdog reset mode is enabled.
// [RL5] Real-time-clock alarm resets only while the processor sleeps.
// [RL6] The mode timer holds reset for 1025 system clock cycles.
// [RL7] Internal sources start the timer on the edge after the request deasserts.
// [RL8] Pin reset starts the timer after three consecutive low cycles are seen.
// [RL9] Clock source defaults to the crystal input after reset.
// [RL10] The reset pin is input and open-drain indicator, pulled low on any event.
// [RL11] The pin is pulled low until the mode timer finishes, then released.
// [RL12] A pin released before time-out lets execution start right after time-out.
// [RL13] A pin still low after time-out needs four high cycles before execution.
// [RL14] Power-on reset holds until detector and stretch end, then the timer runs.
// [RL15] Brownout after run starts reset, lasting until supply recovers and timer ends.
// [RL16] Short brownout dips are ignored by a filter.
// [RL17] Leaving sleep applies the normal mode timer delay.
// [RL18] The brownout-disable bit turns off brownout detection, not power-on reset.
// [RL19] The reset pin passes a two-stage synchroniser before qualification counts.
module reset_sequencer
    import reset_seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire reset_req_t req,
    input  wire logic       brownout_disable_bit,
    input  wire logic       reset_pin_in,
    output logic            reset_pin_out,
    output logic            reset_pin_oe_n,
    output reset_out_t      sys_out
);

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    // Merged internal request after watchdog and alarm qualification
    function automatic logic internal_decode(
        input reset_req_t r,
        input logic       bo_ok
    );
        logic hit;
        hit = r.power_on;                                       // [RL14]
        hit = hit | bo_ok;                                      // [RL15]
        hit = hit | (r.watchdog_timeout & r.watchdog_reset_en); // [RL4]
        hit = hit | (r.rtc_alarm & r.sleeping);                 // [RL5] [RL17]
        hit = hit | r.debug_reset;                              // [RL3]
        return hit;
    endfunction

    // Processor may run: sequencer released and no new event
    function automatic logic run_allowed(
        input seq_state_t s,
        input logic       ev
    );
        logic ok;
        case (s)
            ST_RUN: begin
                ok = !ev;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    // Last count of the mode timer reached
    function automatic logic timer_done(
        input seq_state_t  s,
        input logic [10:0] t
    );
        logic done;
        case (s)
            ST_COUNT: begin
                done = (t == MODE_LAST);
            end
            default: begin
                done = 1'b0;
            end
        endcase
        return done;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchroniser and qualifiers
    // ----------------------------------------------------------------
    logic pin_s;
    logic pin_low_met;
    logic pin_high_met;

    pin_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (reset_pin_in),
        .q       (pin_s)
    ); // [RL19]

    level_qual u_low (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (!pin_s),
        .need    (PIN_LOW_LAST),
        .met     (pin_low_met)
    ); // [RL8]

    level_qual u_high (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (pin_s),
        .need    (PIN_HIGH_LAST),
        .met     (pin_high_met)
    ); // [RL13]

    // ----------------------------------------------------------------
    // Brownout glitch filter
    // ----------------------------------------------------------------
    logic brownout_raw;
    logic brownout_ok;

    assign brownout_raw = req.brownout_detect && !brownout_disable_bit; // [RL18]

    level_qual u_dip (
        .clk_sys (clk_sys),
        .rst     (rst),
        .level   (brownout_raw),
        .need    (DIP_LAST),
        .met     (brownout_ok)
    ); // [RL16]

    // ----------------------------------------------------------------
    // Request merge
    // ----------------------------------------------------------------
    logic internal_req;
    logic any_event;

    always_comb begin
        internal_req = internal_decode(req, brownout_ok); // [RL3]
        any_event    = internal_req | !pin_s;
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    seq_state_t  state_q;
    logic [10:0] timer_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ST_HOLD;
        end else begin
            case (state_q)
                ST_HOLD: begin
                    // Start once internal sources have ended and pin is qualified or high
                    if (internal_req) begin
                        state_q <= ST_HOLD; // [RL14] [RL15]
                    end else if (pin_low_met) begin
                        state_q <= ST_COUNT; // [RL8]
                    end else if (pin_s) begin
                        state_q <= ST_COUNT; // [RL7]
                    end
                end
                ST_COUNT: begin
                    // Counting the oscillator settle time
                    if (internal_req) begin
                        state_q <= ST_HOLD; // [RL3]
                    end else if (timer_done(state_q, timer_q)) begin
                        if (pin_s) begin
                            state_q <= ST_RUN; // [RL12]
                        end else begin
                            state_q <= ST_WAITPIN; // [RL12] [RL13]
                        end
                    end
                end
                ST_WAITPIN: begin
                    if (internal_req) begin
                        state_q <= ST_HOLD;
                    end else if (pin_high_met) begin
                        state_q <= ST_RUN; // [RL13]
                    end
                end
                ST_RUN: begin
                    // Executing until any source or the pin fires
                    if (internal_req) begin
                        state_q <= ST_HOLD; // [RL3] [RL15]
                    end else if (!pin_s) begin
                        state_q <= ST_HOLD; // [RL3]
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Mode timer
    // ----------------------------------------------------------------
    // Runs only while counting and restarts on any fresh internal request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_q <= 11'h000;
        end else begin
            case (state_q)
                ST_COUNT: begin
                    if (internal_req) begin
                        timer_q <= 11'h000; // [RL3]
                    end else begin
                        timer_q <= timer_q + 11'h001; // [RL6]
                    end
                end
                default: begin
                    timer_q <= 11'h000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin driver
    // ----------------------------------------------------------------
    // Data side of the open-drain pad never carries a high
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_pin_out <= 1'b0;
        end else begin
            reset_pin_out <= 1'b0; // [RL10]
        end
    end

    // Enable side pulls the pin low from the event until time-out
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_pin_oe_n <= 1'b0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    reset_pin_oe_n <= run_allowed(state_q, any_event); // [RL10]
                end
                ST_WAITPIN: begin
                    reset_pin_oe_n <= !internal_req; // [RL11]
                end
                ST_COUNT: begin
                    reset_pin_oe_n <= timer_done(state_q, timer_q) && !internal_req; // [RL11]
                end
                ST_HOLD: begin
                    reset_pin_oe_n <= 1'b0; // [RL10]
                end
                default: begin
                    reset_pin_oe_n <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // System outputs
    // ----------------------------------------------------------------
    logic        sys_reset_q;
    logic        cpu_run_q;
    logic        gpio_input_q;
    logic [23:0] pc_q;
    logic [1:0]  clk_src_q;

    // Reset line to the rest of the chip
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_reset_q <= 1'b1;
        end else begin
            sys_reset_q <= !run_allowed(state_q, any_event); // [RL3]
        end
    end

    // Instruction execution only outside reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cpu_run_q <= 1'b0;
        end else begin
            cpu_run_q <= run_allowed(state_q, any_event); // [RL2]
        end
    end

    // Port pins fall back to inputs during reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpio_input_q <= 1'b1;
        end else begin
            gpio_input_q <= !run_allowed(state_q, any_event); // [RL1]
        end
    end

    // Program counter start address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_q <= PC_RESET;
        end else begin
            pc_q <= PC_RESET; // [RL1]
        end
    end

    // Clock source stays on the crystal input
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_src_q <= CLK_SRC_CRYSTAL;
        end else begin
            clk_src_q <= CLK_SRC_CRYSTAL; // [RL9]
        end
    end

    // Output taps, straight from the flip-flops above
    always_comb begin
        sys_out.sys_reset       = sys_reset_q;
        sys_out.cpu_run         = cpu_run_q;
        sys_out.gpio_input_mode = gpio_input_q;
        sys_out.pc_value        = pc_q;
        sys_out.clk_src         = clk_src_q;
    end

endmodule

// *** sim/reset_seq_checker.sv ***
`timescale 1ns/1ns
module reset_seq_checker
    import reset_seq_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire reset_req_t req,
    input  wire logic       brownout_disable_bit,
    input  wire logic       reset_pin_in,
    input  wire logic       reset_pin_out,
    input  wire logic       reset_pin_oe_n,
    input  wire reset_out_t sys_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------
    // Helper counters
    // ----------------------------
    logic        icause;
    logic [10:0] gap_q;
    logic [3:0]  quiet_q;
    logic [2:0]  hi_q;
    assign icause = req.power_on | req.debug_reset | (req.brownout_detect & ~brownout_disable_bit)
                  | (req.watchdog_timeout & req.watchdog_reset_en) | (req.rtc_alarm & req.sleeping);
    always_ff @(posedge clk_sys) begin
        gap_q <= (rst | icause | $fell(reset_pin_oe_n)) ? 11'h000 : gap_q + 11'h001;
    end
    always_ff @(posedge clk_sys) begin
        quiet_q <= (icause | ~reset_pin_in) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
    always_ff @(posedge clk_sys) begin
        hi_q <= ~reset_pin_in ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
    end
    // ----------------------------
    // Properties
    // ----------------------------
    AST_PIN_LOW: assert property (reset_pin_out == 1'h0)
        else $error("reset pin output not low");
    AST_EVENT_PULL: assert property (sys_out.cpu_run && req.debug_reset |=>
        !reset_pin_oe_n && sys_out.sys_reset) else $error("debug request not answered");
    AST_HALT: assert property (sys_out.sys_reset |-> !sys_out.cpu_run
        && sys_out.pc_value == PC_RESET && sys_out.gpio_input_mode) else $error("reset state wrong");
    AST_CLK_SRC: assert property (sys_out.clk_src == CLK_SRC_CRYSTAL)
        else $error("clock source not crystal");
    AST_NO_CAUSE: assert property ($rose(sys_out.sys_reset) |-> quiet_q < 4'h9)
        else $error("reset without cause");
    AST_TIMER: assert property ($rose(reset_pin_oe_n) |-> gap_q inside {[11'h3fe:11'h40a]})
        else $error("mode timer length wrong");
    AST_RUN_HIGH: assert property ($rose(sys_out.cpu_run) |-> hi_q >= 3'h4)
        else $error("run before pin high");
    AST_BROWNOUT: assert property ((req.brownout_detect && !brownout_disable_bit)[*8] |=>
        sys_out.sys_reset) else $error("brownout not reset");
endmodule

// *** sim/reset_pin_partner.sv ***
`timescale 1ns/1ns
module reset_pin_partner (
    input  wire logic oe_n,
    input  wire logic hold_low,
    output logic      pin
);
    // ----------------------------
    // Wired-and line with pull-up
    // ----------------------------
    assign pin = oe_n & ~hold_low;
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    import reset_seq_pkg::*;
    logic       clk_sys = 1'h0;
    logic       rst = 1'h1;
    reset_req_t req = '0;
    logic       bo_off = 1'h0;
    logic       hold_low = 1'h0;
    logic       pin;
    logic       pin_out;
    logic       oe_n;
    reset_out_t sys_out;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         n;
    always #10 clk_sys = ~clk_sys;
    reset_pin_partner PEER (.oe_n(oe_n), .hold_low(hold_low), .pin(pin));
    reset_sequencer DUT (.clk_sys(clk_sys), .rst(rst), .req(req), .brownout_disable_bit(bo_off),
        .reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n), .sys_out(sys_out));
    // ----------------------------
    // Shared tasks
    // ----------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask
    task automatic wait_run(int lo, int hi, string nm);
        n = 0;
        while (sys_out.cpu_run !== 1'h1 && n < 3000) begin
            tick(1);
            n++;
        end
        chk(nm, 32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------
    // Scenarios
    // ----------------------------
    task automatic t_por();
        tick(5);
        req.power_on = 1'h0;
        chk("por_hold", sys_out.sys_reset, 1'h1);
        wait_run(1025, 1040, "por_len");
        chk("pin_rel", oe_n, 1'h1);
        chk("pin_drv", pin_out, 1'h0);
        chk("clk_src", sys_out.clk_src, CLK_SRC_CRYSTAL);
        chk("pc", sys_out.pc_value, PC_RESET);
        $display("t_por done");
    endtask
    task automatic t_masked();
        req.watchdog_timeout = 1'h1;
        req.rtc_alarm = 1'h1;
        tick(20);
        chk("mask_run", sys_out.cpu_run, 1'h1);
        req = '0;
        req.brownout_detect = 1'h1;
        tick(3);
        req.brownout_detect = 1'h0;
        tick(10);
        chk("dip_run", sys_out.cpu_run, 1'h1);
        bo_off = 1'h1;
        req.brownout_detect = 1'h1;
        tick(20);
        chk("bo_off_run", sys_out.cpu_run, 1'h1);
        req = '0;
        bo_off = 1'h0;
        tick(2);
        $display("t_masked done");
    endtask
    task automatic t_sources();
        for (int k = 0; k < 5; k++) begin
            case (k)
                0: req.debug_reset = 1'h1;
                1: req = 7'h18;
                2: req = 7'h06;
                3: req.brownout_detect = 1'h1;
                default: begin
                    bo_off = 1'h1;
                    req.power_on = 1'h1;
                end
            endcase
            tick(10);
            chk("src_reset", sys_out.sys_reset, 1'h1);
            chk("src_pull", oe_n, 1'h0);
            chk("src_gpio", sys_out.gpio_input_mode, 1'h1);
            req = '0;
            wait_run(1025, 1040, "src_len");
        end
        bo_off = 1'h0;
        $display("t_sources done");
    endtask
    task automatic t_pin();
        hold_low = 1'h1;
        tick(10);
        hold_low = 1'h0;
        wait_run(1010, 1040, "pin_short");
        hold_low = 1'h1;
        tick(1200);
        chk("pin_long_held", sys_out.cpu_run, 1'h0);
        chk("pin_long_rel", oe_n, 1'h1);
        hold_low = 1'h0;
        wait_run(4, 12, "pin_long_run");
        $display("t_pin done");
    endtask
    initial begin
        req.power_on = 1'h1;
        tick(6);
        rst = 1'h0;
        t_por();
        t_masked();
        t_sources();
        t_pin();
        close_out();
    end
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule
bind reset_sequencer reset_seq_checker CHK (.clk_sys(clk_sys), .rst(rst), .req(req),
    .brownout_disable_bit(brownout_disable_bit), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .sys_out(sys_out));
